// [nvmem_regs.vh]
`ifndef NVMEM_REGS_VH
`define NVMEM_REGS_VH

// ----------------------------------------
// Register locations
// ----------------------------------------
`define NV_CTRL_ADDR 8'h40
`define NV_CTRL_BANK 1'h1
`define NV_ADDR_SFR 8'h1E
`define NV_DATA_SFR 8'h1F
`define NV_BANK_SFR 8'h04

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define NV_WPERMIT_BIT 3
`define NV_WGO_BIT 2
`define NV_RPERMIT_BIT 1
`define NV_RGO_BIT 0

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define NV_ADDR_W_SMALL 5
`define NV_ADDR_W_LARGE 6
`define NV_REG_RESET 8'h00
`define NV_BANK_RESET 1'h0
`define NV_ZERO_BYTE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define NV_RD_CYCLES 2'h2
`define NV_WR_TICKS 4'h8
`define NV_CNT_ONE 4'h1
`define NV_RCNT_ONE 2'h1

`endif

// [nv_data_memory.v]
`timescale 1ns/1ns
`include "nvmem_regs.vh"

// What this block does
// - Byte array of 32 or 64 entries
// - One byte per access through three registers
// - Control register only at 0x40, bank 1
// - Address field five or six bits, rest zero
// - Write permit bit 3 gates every write
// - Write go bit 2 starts, self-clears after
// - Write go ignored unless permit already set
// - Read permit bit 1 gates every read
// - Read go bit 0 starts, self-clears after
// - Read go ignored unless permit already set
// - Addressed byte in data register after read
// - Data register holds until next operation
// - Write timed by asynchronous internal timer
// - Write end clears go and raises request
// - Power-on clears write permit
// - Power-on selects bank 0
// - Write end sets flag; vectoring clears it
module nv_data_memory #(
	parameter ADDR_W = `NV_ADDR_W_LARGE
) (
	input wire ref_clk,
	input wire nrst,
	input wire clk_en,
	input wire [7:0] sfr_addr,
	input wire sfr_indirect,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	input wire wr_timer_tick,
	input wire write_irq_enable,
	input wire global_irq_enable,
	input wire stack_full,
	input wire irq_ack,
	output wire irq_req,
	output reg write_complete_flag,
	output wire bank_selector,
	output wire nv_busy
);

localparam DEPTH = 1 << ADDR_W;

localparam ST_IDLE = 2'b00;
localparam ST_READ = 2'b01;
localparam ST_WRITE = 2'b10;

// ----------------------------------------
// Storage and registers
// ----------------------------------------
reg [7:0] mem [0:DEPTH-1];
reg [ADDR_W-1:0] nv_address_r;
reg [7:0] nv_data_r;
reg write_permit_r;
reg write_go_r;
reg read_permit_r;
reg read_go_r;
reg bank_selector_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [ADDR_W-1:0] op_addr_r;
reg [7:0] op_data_r;
reg [1:0] rd_cnt_r;
reg [3:0] tick_cnt_r;
reg [1:0] rd_cnt_nxt;
reg [3:0] tick_cnt_nxt;
reg write_permit_nxt;
reg read_permit_nxt;
reg write_go_nxt;
reg read_go_nxt;
reg flag_nxt;
reg [7:0] rdata_nxt;

wire direct_hit_addr;
wire direct_hit_data;
wire direct_hit_bank;
wire ctrl_hit;
wire ctrl_wr;
wire start_write;
wire start_read;
wire tick_edge;
wire write_done;
wire read_done;
wire [7:0] addr_padded;
wire [7:0] ctrl_view;
wire [7:0] bank_view;

// ----------------------------------------
// Decode
// ----------------------------------------
assign direct_hit_addr = !sfr_indirect && (sfr_addr == `NV_ADDR_SFR);
assign direct_hit_data = !sfr_indirect && (sfr_addr == `NV_DATA_SFR);
assign direct_hit_bank = !sfr_indirect && (sfr_addr == `NV_BANK_SFR);
// Reached only through the indirect window with bank 1 selected
assign ctrl_hit = sfr_indirect && (sfr_addr == `NV_CTRL_ADDR) &&
	(bank_selector_r == `NV_CTRL_BANK);
assign ctrl_wr = clk_en && sfr_wr && ctrl_hit;

// Permit must already stand before this write; write wins over read
assign start_write = ctrl_wr && sfr_wdata[`NV_WGO_BIT] &&
	write_permit_r && (state_r == ST_IDLE);
assign start_read = ctrl_wr && sfr_wdata[`NV_RGO_BIT] &&
	read_permit_r && !sfr_wdata[`NV_WGO_BIT] &&
	(state_r == ST_IDLE);

assign addr_padded = {{(8-ADDR_W){1'b0}}, nv_address_r};
assign ctrl_view = {4'h0, write_permit_r, write_go_r,
	read_permit_r, read_go_r};
assign bank_view = {7'h00, bank_selector_r};

// ----------------------------------------
// Write timer filter
// ----------------------------------------
// Tick comes from a free-running oscillator outside this domain
pin_filter tick_filter (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.clk_en(clk_en),
	.pin(wr_timer_tick),
	.level(),
	.rise(tick_edge)
);

assign write_done = (state_r == ST_WRITE) && tick_edge &&
	(tick_cnt_r == `NV_CNT_ONE);
assign read_done = (state_r == ST_READ) && (rd_cnt_r == `NV_RCNT_ONE);

// ----------------------------------------
// Counter next values
// ----------------------------------------
// Freezing clk_en stretches an operation; it never aborts one
always @* begin
	rd_cnt_nxt = rd_cnt_r;
	tick_cnt_nxt = tick_cnt_r;
	if (start_read)
		rd_cnt_nxt = `NV_RD_CYCLES;
	else if (state_r == ST_READ)
		rd_cnt_nxt = rd_cnt_r - `NV_RCNT_ONE;
	// Tick count varies in system cycles with the timer phase
	if (start_write)
		tick_cnt_nxt = `NV_WR_TICKS;
	else if ((state_r == ST_WRITE) && tick_edge)
		tick_cnt_nxt = tick_cnt_r - `NV_CNT_ONE;
end

// ----------------------------------------
// Operation sequencer
// ----------------------------------------
always @* begin
	state_nxt = state_r;
	case (state_r)
	ST_IDLE: begin
		if (start_write)
			state_nxt = ST_WRITE;
		else if (start_read)
			state_nxt = ST_READ;
	end
	ST_READ: begin
		if (read_done)
			state_nxt = ST_IDLE;
	end
	ST_WRITE: begin
		if (write_done)
			state_nxt = ST_IDLE;
	end
	default: state_nxt = ST_IDLE;
	endcase
end

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		state_r <= ST_IDLE;
		op_addr_r <= {ADDR_W{1'b0}};
		op_data_r <= `NV_ZERO_BYTE;
		rd_cnt_r <= 2'h0;
		tick_cnt_r <= 4'h0;
	end else if (clk_en) begin
		state_r <= state_nxt;
		if (start_write || start_read) begin
			op_addr_r <= nv_address_r;
			op_data_r <= nv_data_r;
		end
		rd_cnt_r <= rd_cnt_nxt;
		tick_cnt_r <= tick_cnt_nxt;
	end
end

// ----------------------------------------
// Array write port
// ----------------------------------------
// Not reset: contents survive power loss
always @(posedge ref_clk) begin
	if (clk_en && write_done)
		mem[op_addr_r] <= op_data_r;
end

// ----------------------------------------
// Software registers
// ----------------------------------------
always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		nv_address_r <= {ADDR_W{1'b0}};
		nv_data_r <= `NV_REG_RESET;
		bank_selector_r <= `NV_BANK_RESET;
	end else if (clk_en) begin
		if (sfr_wr && direct_hit_addr)
			nv_address_r <= sfr_wdata[ADDR_W-1:0];
		// Read result wins over a same-cycle software store
		if (read_done)
			nv_data_r <= mem[op_addr_r];
		else if (sfr_wr && direct_hit_data)
			nv_data_r <= sfr_wdata;
		if (sfr_wr && direct_hit_bank)
			bank_selector_r <= sfr_wdata[0];
	end
end

// Go bits: software may only set them; hardware alone clears
// Permits reload on every control write
always @* begin
	write_permit_nxt = write_permit_r;
	read_permit_nxt = read_permit_r;
	write_go_nxt = write_go_r;
	read_go_nxt = read_go_r;
	if (ctrl_wr) begin
		write_permit_nxt = sfr_wdata[`NV_WPERMIT_BIT];
		read_permit_nxt = sfr_wdata[`NV_RPERMIT_BIT];
	end
	if (start_write)
		write_go_nxt = 1'b1;
	else if (write_done)
		write_go_nxt = 1'b0;
	if (start_read)
		read_go_nxt = 1'b1;
	else if (read_done)
		read_go_nxt = 1'b0;
end

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		write_permit_r <= 1'b0;
		read_permit_r <= 1'b0;
		write_go_r <= 1'b0;
		read_go_r <= 1'b0;
	end else if (clk_en) begin
		write_permit_r <= write_permit_nxt;
		read_permit_r <= read_permit_nxt;
		write_go_r <= write_go_nxt;
		read_go_r <= read_go_nxt;
	end
end

// ----------------------------------------
// Write-complete request
// ----------------------------------------
// Completion in the acknowledge cycle keeps the flag set
always @* begin
	flag_nxt = write_complete_flag;
	if (write_done)
		flag_nxt = 1'b1;
	else if (irq_ack)
		flag_nxt = 1'b0;
end

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst)
		write_complete_flag <= 1'b0;
	else if (clk_en)
		write_complete_flag <= flag_nxt;
end

assign irq_req = write_complete_flag && write_irq_enable &&
	global_irq_enable && !stack_full;

// ----------------------------------------
// Read data path
// ----------------------------------------
always @* begin
	rdata_nxt = `NV_ZERO_BYTE;
	if (direct_hit_addr)
		rdata_nxt = addr_padded;
	else if (direct_hit_data)
		rdata_nxt = nv_data_r;
	else if (direct_hit_bank)
		rdata_nxt = bank_view;
	else if (ctrl_hit)
		rdata_nxt = ctrl_view;
end

// Holds between reads so a late sample still sees the byte
always @(posedge ref_clk or negedge nrst) begin
	if (!nrst)
		sfr_rdata <= `NV_ZERO_BYTE;
	else if (clk_en && sfr_rd)
		sfr_rdata <= rdata_nxt;
end

assign bank_selector = bank_selector_r;
assign nv_busy = (state_r != ST_IDLE);

endmodule // nv_data_memory

// ----------------------------------------
// Three-flop pin filter
// ----------------------------------------
// A level counts once the second and third flops agree, so a
// metastable settle never makes a false edge
// Limitation: a pulse shorter than two cycles may be lost
module pin_filter (
	input wire ref_clk,
	input wire nrst,
	input wire clk_en,
	input wire pin,
	output wire level,
	output wire rise
);

reg [2:0] sync_r;
reg level_r;
wire agree;

assign agree = (sync_r[1] == sync_r[2]);
assign rise = agree && sync_r[2] && !level_r;
assign level = level_r;

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		sync_r <= 3'h0;
		level_r <= 1'b0;
	end else if (clk_en) begin
		sync_r <= {sync_r[1:0], pin};
		if (agree)
			level_r <= sync_r[2];
	end
end

endmodule // pin_filter

// [nv_checker.sv]
`timescale 1ns/1ns
`include "nvmem_regs.vh"
module nv_checker #(
	parameter ADDR_W = 6
) (
	input wire ref_clk,
	input wire nrst,
	input wire clk_en,
	input wire [7:0] sfr_addr,
	input wire sfr_indirect,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire write_irq_enable,
	input wire global_irq_enable,
	input wire stack_full,
	input wire irq_ack,
	input wire irq_req,
	input wire write_complete_flag,
	input wire bank_selector,
	input wire nv_busy
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
a_irq_level: assert property (irq_req == (write_complete_flag &&
	write_irq_enable && global_irq_enable && !stack_full)) else $error("irq");
a_flag_at_end: assert property ($rose(write_complete_flag) |->
	$fell(nv_busy)) else $error("flag not at end");
a_ack_clears: assert property (irq_ack && clk_en && !nv_busy |=>
	!write_complete_flag) else $error("ack ignored");
a_busy_bounded: assert property ($rose(nv_busy) |->
	##[1:400] !nv_busy) else $error("busy too long");
a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
	else $error("rdata moved");
a_bank_loads: assert property (sfr_wr && clk_en && !sfr_indirect &&
	sfr_addr == `NV_BANK_SFR |=> bank_selector == $past(sfr_wdata[0]))
	else $error("bank");
a_ctrl_hidden: assert property (sfr_rd && clk_en && sfr_indirect &&
	!bank_selector |=> sfr_rdata == 8'h00) else $error("hidden");
a_addr_width: assert property (sfr_rd && clk_en && !sfr_indirect &&
	sfr_addr == `NV_ADDR_SFR |=> (sfr_rdata >> ADDR_W) == 8'h00)
	else $error("addr width");
endmodule // nv_checker
bind nv_data_memory nv_checker #(.ADDR_W(ADDR_W)) chk (.*);

// [cpu_model.sv]
`timescale 1ns/1ns
`include "nvmem_regs.vh"
module cpu_model (
	input wire ref_clk,
	input wire [7:0] sfr_rdata,
	output reg [7:0] sfr_addr,
	output reg sfr_indirect,
	output reg sfr_wr,
	output reg sfr_rd,
	output reg [7:0] sfr_wdata,
	output reg global_irq_enable
);
reg [7:0] q;
integer i;
initial begin
	{sfr_addr, sfr_indirect, sfr_wr, sfr_rd, sfr_wdata} = 19'h0;
	global_irq_enable = 1'b1;
	q = 8'h00;
end
task acc(input [7:0] a, input ind, input w, input [7:0] d);
	begin
		@(posedge ref_clk);
		{sfr_addr, sfr_indirect, sfr_wdata} <= {a, ind, d};
		{sfr_wr, sfr_rd} <= {w, !w};
		@(posedge ref_clk);
		{sfr_wr, sfr_rd} <= 2'h0;
		// Released data lines must not keep the old byte
		sfr_wdata <= ~d;
		#1 q = sfr_rdata;
	end
endtask
task wr(input [7:0] a, input ind, input [7:0] d);
	acc(a, ind, 1'b1, d);
endtask
task rd(input [7:0] a, input ind);
	acc(a, ind, 1'b0, 8'h00);
endtask
task poll(input [7:0] m);
	begin
		q = m;
		for (i = 0; i < 300 && (q & m) != 8'h00; i = i + 1)
			rd(`NV_CTRL_ADDR, 1'b1);
	end
endtask
task nvw(input [7:0] a, input [7:0] d);
	begin
		wr(`NV_ADDR_SFR, 1'b0, a);
		wr(`NV_DATA_SFR, 1'b0, d);
		wr(`NV_BANK_SFR, 1'b0, 8'h01);
		@(posedge ref_clk) global_irq_enable <= 1'b0;
		wr(`NV_CTRL_ADDR, 1'b1, 8'h08);
		wr(`NV_CTRL_ADDR, 1'b1, 8'h0C);
		@(posedge ref_clk) global_irq_enable <= 1'b1;
	end
endtask
task nvr(input [7:0] a);
	begin
		wr(`NV_ADDR_SFR, 1'b0, a);
		wr(`NV_CTRL_ADDR, 1'b1, 8'h02);
		wr(`NV_CTRL_ADDR, 1'b1, 8'h03);
		poll(8'h01);
		rd(`NV_DATA_SFR, 1'b0);
	end
endtask
endmodule // cpu_model

// [testbench.sv]
`timescale 1ns/1ns
`include "nvmem_regs.vh"
`define CHK(n, e, s) begin tests_run = tests_run + 1; if ((s) !== (e)) begin \
	errors = errors + 1; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
reg ref_clk, nrst, stack_full, irq_ack, write_irq_enable, clk_en;
reg [3:0] tc;
wire [7:0] sfr_addr, sfr_wdata, sfr_rdata;
wire sfr_indirect, sfr_wr, sfr_rd, global_irq_enable, irq_req;
wire write_complete_flag, bank_selector, nv_busy;
integer errors, tests_run;
// Write timer: period 16 cycles, high 8, meets the tick spacing
nv_data_memory #(.ADDR_W(6)) DUT (.*, .wr_timer_tick(tc[3]));
cpu_model cpu (.*);
initial begin
	ref_clk = 1'b0;
	forever #5 ref_clk = ~ref_clk;
end
always @(posedge ref_clk) tc <= tc + 4'h1;
initial begin
	#100000 errors = errors + 1;
	conclude;
end
task conclude;
	begin
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	end
endtask
task t_reset;
	begin
		cpu.rd(`NV_DATA_SFR, 1'b0);
		`CHK("data", 8'h00, cpu.q)
		`CHK("bank", 1'b0, bank_selector)
		cpu.wr(`NV_CTRL_ADDR, 1'b1, 8'h0A);
		cpu.rd(`NV_CTRL_ADDR, 1'b1);
		`CHK("hidden", 8'h00, cpu.q)
		cpu.wr(`NV_BANK_SFR, 1'b0, 8'h01);
		cpu.rd(`NV_CTRL_ADDR, 1'b1);
		`CHK("control", 8'h00, cpu.q)
		cpu.wr(`NV_ADDR_SFR, 1'b0, 8'hFF);
		cpu.rd(`NV_ADDR_SFR, 1'b0);
		`CHK("address", 8'h3F, cpu.q)
	end
endtask
task t_refuse(input [7:0] d, input [7:0] e);
	begin
		cpu.wr(`NV_CTRL_ADDR, 1'b1, 8'h00);
		cpu.wr(`NV_CTRL_ADDR, 1'b1, d);
		cpu.rd(`NV_CTRL_ADDR, 1'b1);
		`CHK("go refused", e, cpu.q)
		`CHK("idle", 1'b0, nv_busy)
	end
endtask
task t_write;
	begin
		cpu.nvw(8'h3F, 8'hA5);
		cpu.poll(8'h04);
		`CHK("control", 8'h08, cpu.q)
		`CHK("flag", 1'b1, write_complete_flag)
		`CHK("irq", 1'b1, irq_req)
		@(posedge ref_clk) write_irq_enable <= 1'b0;
		@(posedge ref_clk) #1 `CHK("irq off", 1'b0, irq_req)
		@(posedge ref_clk) write_irq_enable <= 1'b1;
		@(posedge ref_clk) stack_full <= 1'b1;
		@(posedge ref_clk) #1 `CHK("irq", 1'b0, irq_req)
		@(posedge ref_clk) {stack_full, irq_ack} <= 2'h1;
		@(posedge ref_clk) irq_ack <= 1'b0;
		#1 `CHK("flag", 1'b0, write_complete_flag)
		cpu.nvw(8'h00, 8'h5A);
		cpu.poll(8'h04);
		cpu.nvr(8'h3F);
		`CHK("read", 8'hA5, cpu.q)
		cpu.nvr(8'h00);
		`CHK("read", 8'h5A, cpu.q)
	end
endtask
task t_freeze;
	begin
		@(posedge ref_clk) clk_en <= 1'b0;
		cpu.wr(`NV_BANK_SFR, 1'b0, 8'h00);
		@(posedge ref_clk) clk_en <= 1'b1;
		#1 `CHK("frozen bank", 1'b1, bank_selector)
		cpu.wr(`NV_CTRL_ADDR, 1'b1, 8'h0A);
		@(posedge ref_clk) nrst <= 1'b0;
		@(posedge ref_clk) nrst <= 1'b1;
		#1 `CHK("bank", 1'b0, bank_selector)
		cpu.wr(`NV_BANK_SFR, 1'b0, 8'h01);
		cpu.rd(`NV_CTRL_ADDR, 1'b1);
		`CHK("control", 8'h00, cpu.q)
	end
endtask
initial begin
	{tc, nrst, stack_full, irq_ack, write_irq_enable, clk_en} = 9'h003;
	{errors, tests_run} = 0;
	repeat (6) @(posedge ref_clk);
	nrst <= 1'b1;
	t_reset;
	t_refuse(8'h0C, 8'h08);
	t_refuse(8'h04, 8'h00);
	t_refuse(8'h03, 8'h02);
	t_write;
	t_freeze;
	conclude;
end
endmodule // testbench
